// File: rtl/ckg_cfg.svh
// Register map, field positions, reset values and limits of the clock router
`ifndef CKG_CFG_SVH
`define CKG_CFG_SVH

// Word addresses on the register bus
`define CKG_REG_CTRL        6'h00
`define CKG_REG_EN          6'h01
`define CKG_REG_STAT        6'h02
`define CKG_REG_OUT0        6'h08

// Control register fields
`define CKG_CTRL_P1_SRC     0
`define CKG_CTRL_P2_SRC     1
`define CKG_CTRL_EXTF_LSB   2
`define CKG_CTRL_EXTF_MSB   8
`define CKG_CTRL_SSD_LSB    9
`define CKG_CTRL_SSD_MSB    12
`define CKG_CTRL_MASK       32'h0000_1fff
`define CKG_CTRL_RST        32'h0000_0028

// Per-output configuration fields
`define CKG_OUT_PLL         0
`define CKG_OUT_INV         1
`define CKG_OUT_PARK_LSB    2
`define CKG_OUT_PARK_MSB    3
`define CKG_OUT_REXP_LSB    4
`define CKG_OUT_REXP_MSB    6
`define CKG_OUT_SS          7
`define CKG_OUT_PULL        8
`define CKG_OUT_DINT_LSB    16
`define CKG_OUT_DINT_MSB    23
`define CKG_OUT_FRAC_LSB    24
`define CKG_OUT_FRAC_MSB    31
`define CKG_OUT_MASK        32'hffff_01ff
`define CKG_OUT_RST         32'h0004_0010

// Status register fields
`define CKG_STAT_GATE       8
`define CKG_STAT_SSD        9
`define CKG_STAT_DIV_LSB    10

// Frequency limits in MHz
`define CKG_EXT_MIN_MHZ     7'h0a
`define CKG_EXT_MAX_MHZ     7'h64
`define CKG_PLL_REF_MAX_MHZ 7'h1e
`define CKG_PLL_REF_X2_MHZ  7'h3c

// Divider limits
`define CKG_FD_DIV_MIN      8'h02
`define CKG_REXP_MIN        3'h1
`define CKG_SS_PRE_MAX      8'h63

`endif

// File: rtl/ckg_pkg.sv
// Types shared by the clock router files
package ckg_pkg;
	typedef enum logic [1:0] {
		CKG_PARK_LOW  = 2'b00,
		CKG_PARK_HIGH = 2'b01,
		CKG_PARK_HIZ  = 2'b10
	} ckg_park_t;

	typedef enum logic {
		CKG_BUS_IDLE = 1'b0,
		CKG_BUS_ACK  = 1'b1
	} ckg_bus_t;
endpackage

// File: rtl/ckg_out_gate.sv
// Glitchless output gate with park state for one clock output
`timescale 1ns/100ps
`default_nettype none
module ckg_out_gate (
	// Clock and reset
	input  wire logic            i_ref_clk,
	input  wire logic            i_reset_n,
	// Divided clock and settings
	input  wire logic            i_src,
	input  wire logic            i_enable,
	input  wire logic            i_gate_pin_n,
	input  wire logic            i_invert,
	input  wire ckg_pkg::ckg_park_t i_park,
	input  wire logic            i_powered,
	// Pin and state
	output logic                 o_pin,
	output logic                 o_pin_oe_n,
	output logic                 o_running
);
	import ckg_pkg::*;

	logic en_s1, en_s2, gate_s1, gate_s2;
	logic src_prev, running, pin, oe_n;
	logic next_running, next_pin, next_oe_n, want, rise, park_hiz;

	always_comb begin
		want = en_s2 & ~gate_s2; // R18 R9 R17
		rise = i_src & ~src_prev;
		next_running = running;
		// Decided only on a leading edge: starts whole, stops after a full cycle
		if (rise) begin
			next_running = want; // R11 R12
		end
		park_hiz = 1'b1;
		unique case (i_park)
			CKG_PARK_LOW:  park_hiz = 1'b0;
			CKG_PARK_HIGH: park_hiz = 1'b0;
			CKG_PARK_HIZ:  park_hiz = 1'b1;
			default:       park_hiz = 1'b1;
		endcase
		if (next_running) begin
			next_pin = i_src ^ i_invert; // R16
		end else begin
			next_pin = (i_park == CKG_PARK_HIGH); // R10
		end
		next_oe_n = ~i_powered | (~next_running & park_hiz); // R10 R14
	end

	always_ff @(posedge i_ref_clk or negedge i_reset_n) begin
		if (!i_reset_n) begin
			en_s1    <= 1'b0;
			en_s2    <= 1'b0;
			gate_s1  <= 1'b1;
			gate_s2  <= 1'b1;
			src_prev <= 1'b0;
			running  <= 1'b0;
			pin      <= 1'b0;
			oe_n     <= 1'b1;
		end else begin
			en_s1    <= i_enable;
			en_s2    <= en_s1;
			gate_s1  <= i_gate_pin_n;
			gate_s2  <= gate_s1;
			src_prev <= i_src;
			running  <= next_running;
			pin      <= next_pin;
			oe_n     <= next_oe_n;
		end
	end

	assign o_pin      = pin;
	assign o_pin_oe_n = oe_n;
	assign o_running  = running;
endmodule
`default_nettype wire

// File: rtl/ckg_clock_route.sv
// Clock routing, dividers, spread control and output gating with register slave
//
// The Avalon-MM slave port and the address map are this design's own decisions.
`timescale 1ns/100ps
`default_nettype none
`include "ckg_cfg.svh"
// How it works
// (R1) Each PLL picks crystal or external reference
// (R2) Each divider picks first or second PLL
// (R3) Input divider keeps PLL reference within limit
// (R4) Pulled clocks come only from second PLL
// (R5) Pulled divider frequency capped by divider minimum
// (R6) Divider ratio clamped to its least value
// (R7) Integer output divider follows each divider
// (R8) Spread only on first PLL outputs
// (R9) Gate pin low runs, high disables
// (R10) Disabled output parks high, low, or Hi-Z
// (R11) Output starts on first leading edge
// (R12) Output finishes full cycle before stopping
// (R13) Spread-defeat pin low suppresses all spread
// (R14) Outputs form four banks of two
// (R15) Output divider is two to power one..seven
// (R16) Per-output polarity inversion before the pin
// (R17) Per-output enable setting
// (R18) Enable and gate pin synchronized before gating
module ckg_clock_route #(
	parameter int NUM_OUT = 8
) (
	// Clock and reset
	input  wire logic                 i_ref_clk,
	input  wire logic                 i_reset_n,
	// Avalon-MM slave
	input  wire logic [5:0]           i_avs_address,
	input  wire logic                 i_avs_read,
	input  wire logic                 i_avs_write,
	input  wire logic [31:0]          i_avs_writedata,
	input  wire logic [3:0]           i_avs_byteenable,
	output logic [31:0]               o_avs_readdata,
	output logic                      o_avs_waitrequest,
	// References and control pins
	input  wire logic                 i_crystal_ref,
	input  wire logic                 i_external_ref_input,
	input  wire logic                 i_output_gate_pin_n,
	input  wire logic                 i_spread_defeat_pin,
	input  wire logic [NUM_OUT/2-1:0] i_bank_output_supply,
	// Clock outputs
	output logic [NUM_OUT-1:0]        o_clk,
	output logic [NUM_OUT-1:0]        o_clk_oe_n,
	// Reference steering
	output logic                      o_first_pll_ref_sel,
	output logic                      o_second_pll_ref_sel,
	output logic [1:0]                o_ext_div_code
);
	import ckg_pkg::*;

	if (NUM_OUT < 2 || NUM_OUT > 8 || (NUM_OUT % 2) != 0) begin : g_bad_num_out
		$error("NUM_OUT must be an even count from 2 to 8");
	end

	function automatic logic [31:0] ckg_wmask(input logic [31:0] old_v,
		input logic [31:0] wd, input logic [3:0] be, input logic [31:0] mask);
		logic [31:0] v;
		v = old_v;
		for (int b = 0; b < 4; b++) begin
			if (be[b]) begin
				v[b*8 +: 8] = wd[b*8 +: 8];
			end
		end
		return v & mask;
	endfunction

	// Register state
	ckg_bus_t            bus_st, next_bus_st;
	logic [31:0]         rdata, next_rdata, rd_mux;
	logic [31:0]         ctrl, next_ctrl;
	logic [NUM_OUT-1:0]  en, next_en;
	logic [31:0]         cfg [NUM_OUT];
	logic [31:0]         next_cfg [NUM_OUT];
	logic [5:0]          out_idx;
	logic                out_hit;
	logic [NUM_OUT-1:0]  running;

	// Reference path
	logic [6:0] ext_mhz;
	logic [1:0] div_code;
	logic       ext_prev, next_ext_prev, ext_lvl, pll1_lvl, pll2_lvl;
	logic [1:0] ext_cnt, next_ext_cnt;

	// Spread triangle
	logic [7:0] ss_pre, next_ss_pre;
	logic [3:0] ss_tri, next_ss_tri, ss_depth, ss_ofs;
	logic       ss_up, next_ss_up;

	assign out_idx = i_avs_address - `CKG_REG_OUT0;
	assign out_hit = (i_avs_address >= `CKG_REG_OUT0) &&
		(out_idx < 6'(NUM_OUT));

	always_comb begin
		rd_mux = 32'h0000_0000;
		if (i_avs_address == `CKG_REG_CTRL) begin
			rd_mux = ctrl;
		end else if (i_avs_address == `CKG_REG_EN) begin
			rd_mux = 32'(en);
		end else if (i_avs_address == `CKG_REG_STAT) begin
			rd_mux = 32'(running);
			rd_mux[`CKG_STAT_GATE] = i_output_gate_pin_n;
			rd_mux[`CKG_STAT_SSD] = i_spread_defeat_pin;
			rd_mux[`CKG_STAT_DIV_LSB +: 2] = div_code;
		end else if (out_hit) begin
			rd_mux = cfg[out_idx[2:0]];
		end
	end

	// One wait cycle per access; write lands on the edge that ends the acknowledge cycle
	always_comb begin
		next_bus_st = bus_st;
		next_rdata = rdata;
		next_ctrl = ctrl;
		next_en = en;
		for (int i = 0; i < NUM_OUT; i++) begin
			next_cfg[i] = cfg[i];
		end
		unique case (bus_st)
			CKG_BUS_IDLE: begin
				if (i_avs_read || i_avs_write) begin
					next_bus_st = CKG_BUS_ACK;
					next_rdata = i_avs_read ? rd_mux : 32'h0000_0000;
				end
			end
			CKG_BUS_ACK: begin
				next_bus_st = CKG_BUS_IDLE;
				if (i_avs_write) begin
					if (i_avs_address == `CKG_REG_CTRL) begin
						next_ctrl = ckg_wmask(ctrl, i_avs_writedata,
							i_avs_byteenable, `CKG_CTRL_MASK);
					end else if (i_avs_address == `CKG_REG_EN) begin
						next_en = NUM_OUT'(ckg_wmask(32'(en), i_avs_writedata,
							i_avs_byteenable, 32'hffff_ffff)); // R17
					end else if (out_hit) begin
						next_cfg[out_idx[2:0]] = ckg_wmask(cfg[out_idx[2:0]],
							i_avs_writedata, i_avs_byteenable, `CKG_OUT_MASK);
					end
				end
			end
		endcase
	end

	always_ff @(posedge i_ref_clk or negedge i_reset_n) begin
		if (!i_reset_n) begin
			bus_st <= CKG_BUS_IDLE;
			rdata  <= 32'h0000_0000;
			ctrl   <= `CKG_CTRL_RST;
			en     <= '0;
			for (int i = 0; i < NUM_OUT; i++) begin
				cfg[i] <= `CKG_OUT_RST;
			end
		end else begin
			bus_st <= next_bus_st;
			rdata  <= next_rdata;
			ctrl   <= next_ctrl;
			en     <= next_en;
			for (int i = 0; i < NUM_OUT; i++) begin
				cfg[i] <= next_cfg[i];
			end
		end
	end

	assign o_avs_waitrequest = (i_avs_read | i_avs_write) & (bus_st == CKG_BUS_IDLE);
	assign o_avs_readdata = rdata;

	// Smallest power-of-two ratio that brings the reference under the limit
	always_comb begin
		ext_mhz = ctrl[`CKG_CTRL_EXTF_MSB:`CKG_CTRL_EXTF_LSB];
		if (ext_mhz < `CKG_EXT_MIN_MHZ) begin
			ext_mhz = `CKG_EXT_MIN_MHZ;
		end else if (ext_mhz > `CKG_EXT_MAX_MHZ) begin
			ext_mhz = `CKG_EXT_MAX_MHZ;
		end
		if (ext_mhz <= `CKG_PLL_REF_MAX_MHZ) begin
			div_code = 2'h0; // R3
		end else if (ext_mhz <= `CKG_PLL_REF_X2_MHZ) begin
			div_code = 2'h1; // R3
		end else begin
			div_code = 2'h2; // R3
		end
		next_ext_prev = i_external_ref_input;
		next_ext_cnt = ext_cnt;
		if (i_external_ref_input && !ext_prev) begin
			next_ext_cnt = 2'(ext_cnt + 2'h1);
		end
		unique case (div_code)
			2'h0:    ext_lvl = i_external_ref_input;
			2'h1:    ext_lvl = ext_cnt[0];
			default: ext_lvl = ext_cnt[1];
		endcase
		pll1_lvl = ctrl[`CKG_CTRL_P1_SRC] ? ext_lvl : i_crystal_ref; // R1
		pll2_lvl = ctrl[`CKG_CTRL_P2_SRC] ? ext_lvl : i_crystal_ref; // R1
	end

	always_ff @(posedge i_ref_clk or negedge i_reset_n) begin
		if (!i_reset_n) begin
			ext_prev <= 1'b0;
			ext_cnt  <= 2'h0;
		end else begin
			ext_prev <= next_ext_prev;
			ext_cnt  <= next_ext_cnt;
		end
	end

	assign o_first_pll_ref_sel  = ctrl[`CKG_CTRL_P1_SRC];
	assign o_second_pll_ref_sel = ctrl[`CKG_CTRL_P2_SRC];
	assign o_ext_div_code       = div_code;

	// Triangle profile; the depth field caps the added fraction
	always_comb begin
		ss_depth = ctrl[`CKG_CTRL_SSD_MSB:`CKG_CTRL_SSD_LSB];
		next_ss_pre = 8'(ss_pre + 8'h01);
		next_ss_tri = ss_tri;
		next_ss_up = ss_up;
		if (ss_pre >= `CKG_SS_PRE_MAX) begin
			next_ss_pre = 8'h00;
			if (ss_up) begin
				next_ss_tri = 4'(ss_tri + 4'h1);
				next_ss_up = (ss_tri != 4'he);
			end else begin
				next_ss_tri = 4'(ss_tri - 4'h1);
				next_ss_up = (ss_tri == 4'h1);
			end
		end
		ss_ofs = (ss_tri > ss_depth) ? ss_depth : ss_tri;
	end

	always_ff @(posedge i_ref_clk or negedge i_reset_n) begin
		if (!i_reset_n) begin
			ss_pre <= 8'h00;
			ss_tri <= 4'h0;
			ss_up  <= 1'b1;
		end else begin
			ss_pre <= next_ss_pre;
			ss_tri <= next_ss_tri;
			ss_up  <= next_ss_up;
		end
	end

	for (genvar g = 0; g < NUM_OUT; g++) begin : g_out
		logic       src, src_prev, fd, next_fd, ss_on, rise;
		logic [7:0] cnt, next_cnt, acc, next_acc, dint;
		logic [1:0] car, next_car;
		logic [9:0] sum;
		logic [8:0] lim;
		logic [6:0] rcnt, next_rcnt;
		logic [2:0] rexp;
		logic       r_lvl;

		always_comb begin
			// Pulled mode forces the second PLL and excludes spread
			src = (cfg[g][`CKG_OUT_PLL] | cfg[g][`CKG_OUT_PULL]) ?
				pll2_lvl : pll1_lvl; // R2 R4
			ss_on = cfg[g][`CKG_OUT_SS] & ~cfg[g][`CKG_OUT_PLL] &
				~cfg[g][`CKG_OUT_PULL] & i_spread_defeat_pin; // R8 R13
			dint = cfg[g][`CKG_OUT_DINT_MSB:`CKG_OUT_DINT_LSB];
			if (dint < `CKG_FD_DIV_MIN) begin
				dint = `CKG_FD_DIV_MIN; // R5 R6
			end
			lim = 9'(dint) + 9'(car);
			sum = 10'(acc) + 10'(cfg[g][`CKG_OUT_FRAC_MSB:`CKG_OUT_FRAC_LSB]) +
				10'(ss_on ? ss_ofs : 4'h0);
			rise = src & ~src_prev;
			next_cnt = cnt;
			next_acc = acc;
			next_car = car;
			next_fd = fd;
			if (rise) begin
				if (9'(cnt) + 9'h001 >= lim) begin
					next_cnt = 8'h00;
					next_acc = sum[7:0];
					next_car = sum[9:8];
					next_fd = ~fd;
				end else begin
					next_cnt = 8'(cnt + 8'h01);
				end
			end
			next_rcnt = rcnt;
			if (next_fd && !fd) begin
				next_rcnt = 7'(rcnt + 7'h01); // R7
			end
			rexp = cfg[g][`CKG_OUT_REXP_MSB:`CKG_OUT_REXP_LSB];
			if (rexp < `CKG_REXP_MIN) begin
				rexp = `CKG_REXP_MIN; // R15
			end
			r_lvl = rcnt[rexp - `CKG_REXP_MIN]; // R15
		end

		always_ff @(posedge i_ref_clk or negedge i_reset_n) begin
			if (!i_reset_n) begin
				src_prev <= 1'b0;
				cnt      <= 8'h00;
				acc      <= 8'h00;
				car      <= 2'h0;
				fd       <= 1'b0;
				rcnt     <= 7'h00;
			end else begin
				src_prev <= src;
				cnt      <= next_cnt;
				acc      <= next_acc;
				car      <= next_car;
				fd       <= next_fd;
				rcnt     <= next_rcnt;
			end
		end

		ckg_out_gate u_gate (
			.i_ref_clk    (i_ref_clk),
			.i_reset_n    (i_reset_n),
			.i_src        (r_lvl),
			.i_enable     (en[g]),
			.i_gate_pin_n (i_output_gate_pin_n),
			.i_invert     (cfg[g][`CKG_OUT_INV]),
			.i_park       (ckg_park_t'(cfg[g][`CKG_OUT_PARK_MSB:`CKG_OUT_PARK_LSB])),
			.i_powered    (i_bank_output_supply[g/2]), // R14
			.o_pin        (o_clk[g]),
			.o_pin_oe_n   (o_clk_oe_n[g]),
			.o_running    (running[g])
		);
	end
endmodule
`default_nettype wire

// File: verif/ckg_route_properties.sv
// Port-level checks on the clock router
`timescale 1ns/100ps
`default_nettype none
module ckg_route_properties #(
	parameter int NUM_OUT = 8
) (
	// Clock and reset
	input  wire logic                 i_ref_clk,
	input  wire logic                 i_reset_n,
	// Register bus
	input  wire logic [5:0]           i_avs_address,
	input  wire logic                 i_avs_read,
	input  wire logic                 i_avs_write,
	input  wire logic [31:0]          o_avs_readdata,
	input  wire logic                 o_avs_waitrequest,
	// Pins and outputs
	input  wire logic                 i_output_gate_pin_n,
	input  wire logic                 i_spread_defeat_pin,
	input  wire logic [NUM_OUT/2-1:0] i_bank_output_supply,
	input  wire logic [NUM_OUT-1:0]   o_clk,
	input  wire logic [NUM_OUT-1:0]   o_clk_oe_n,
	input  wire logic                 o_first_pll_ref_sel,
	input  wire logic                 o_second_pll_ref_sel,
	input  wire logic [1:0]           o_ext_div_code
);
	// Covers the slowest divided clock the bench runs
	localparam int SETTLE = 200;
	logic [7:0] hi_cnt;
	logic [2:0] pin_cnt;
	logic       unmapped;
	logic       ctrl_wr;

	default clocking @(posedge i_ref_clk); endclocking
	default disable iff (!i_reset_n);

	assign unmapped = (i_avs_address > 6'h02 && i_avs_address < 6'h08)
		|| (i_avs_address >= 6'(8 + NUM_OUT));
	assign ctrl_wr = i_avs_write && !o_avs_waitrequest && i_avs_address == 6'h00;

	always_ff @(posedge i_ref_clk or negedge i_reset_n) begin
		if (!i_reset_n) begin
			hi_cnt <= 8'h00;
			pin_cnt <= 3'h0;
		end else begin
			// A write or supply change may legally move a parked pin
			if (!i_output_gate_pin_n || i_avs_write || $changed(i_bank_output_supply))
				hi_cnt <= 8'h00;
			else if (hi_cnt != 8'hff)
				hi_cnt <= hi_cnt + 8'h01;
			if ($changed(i_output_gate_pin_n) || $changed(i_spread_defeat_pin))
				pin_cnt <= 3'h0;
			else if (pin_cnt != 3'h7)
				pin_cnt <= pin_cnt + 3'h1;
		end
	end

	sequence wait_then_ack_s;
		o_avs_waitrequest ##1 !o_avs_waitrequest;
	endsequence

	bus_one_wait_a: assert property ($rose(i_avs_read || i_avs_write) |-> wait_then_ack_s)
		else $error("bus answer not after one wait cycle");
	bus_idle_free_a: assert property (!(i_avs_read || i_avs_write) |-> !o_avs_waitrequest)
		else $error("waitrequest without request");
	unmapped_zero_a: assert property (i_avs_read && !o_avs_waitrequest && unmapped
		|-> o_avs_readdata == 32'h0) else $error("unmapped read not zero");
	first_sel_cause_a: assert property ($changed(o_first_pll_ref_sel) |-> $past(ctrl_wr))
		else $error("first reference select moved without write");
	second_sel_cause_a: assert property ($changed(o_second_pll_ref_sel) |-> $past(ctrl_wr))
		else $error("second reference select moved without write");
	ext_code_cause_a: assert property ($changed(o_ext_div_code) |-> $past(ctrl_wr))
		else $error("input divider moved without write");
	ext_code_legal_a: assert property (o_ext_div_code != 2'h3)
		else $error("input divider code out of range");
	gate_park_hold_a: assert property (hi_cnt >= SETTLE |-> $stable(o_clk) && $stable(o_clk_oe_n))
		else $error("output moved while gated off");
	stat_pins_a: assert property (i_avs_read && o_avs_waitrequest && i_avs_address == 6'h02
		&& pin_cnt >= 3'h4 |=> o_avs_readdata[9:8] == {i_spread_defeat_pin, i_output_gate_pin_n})
		else $error("status pin bits wrong");
endmodule

bind ckg_clock_route ckg_route_properties #(.NUM_OUT(NUM_OUT)) u_props (
	.i_ref_clk(i_ref_clk), .i_reset_n(i_reset_n), .i_avs_address(i_avs_address),
	.i_avs_read(i_avs_read), .i_avs_write(i_avs_write), .o_avs_readdata(o_avs_readdata),
	.o_avs_waitrequest(o_avs_waitrequest), .i_output_gate_pin_n(i_output_gate_pin_n),
	.i_spread_defeat_pin(i_spread_defeat_pin), .i_bank_output_supply(i_bank_output_supply),
	.o_clk(o_clk), .o_clk_oe_n(o_clk_oe_n), .o_first_pll_ref_sel(o_first_pll_ref_sel),
	.o_second_pll_ref_sel(o_second_pll_ref_sel), .o_ext_div_code(o_ext_div_code));
`default_nettype wire

// File: verif/ckg_clk_sink.sv
// Downstream consumer timing every phase of one output clock
`timescale 1ns/100ps
`default_nettype none
module ckg_clk_sink (
	// Clock and control
	input  wire logic i_ref_clk,
	input  wire logic i_clear,
	// Watched output
	input  wire logic i_line,
	input  wire logic i_oe_n,
	// Measurements
	output var int    o_rises,
	output var int    o_min_hi,
	output var int    o_max_hi,
	output var int    o_min_lo,
	output var int    o_max_lo,
	output var logic  o_first
);
	int   run = 0;
	logic last = 1'b0;
	logic was_off = 1'b1;

	task keep(input logic lvl, input int w);
		if (lvl) begin
			o_min_hi = (w < o_min_hi) ? w : o_min_hi;
			o_max_hi = (w > o_max_hi) ? w : o_max_hi;
		end else begin
			o_min_lo = (w < o_min_lo) ? w : o_min_lo;
			o_max_lo = (w > o_max_lo) ? w : o_max_lo;
		end
	endtask

	always @(posedge i_ref_clk) begin
		if (i_clear) begin
			o_rises = 0;
			o_min_hi = 9999;
			o_max_hi = 0;
			o_min_lo = 9999;
			o_max_lo = 0;
		end else if (!i_oe_n && was_off) begin
			// Only whole phases are expected, the first one too
			o_first = i_line;
			run = 1;
			o_rises += int'(i_line);
		end else if (!i_oe_n && i_line !== last) begin
			keep(last, run);
			run = 1;
			o_rises += int'(i_line);
		end else if (i_oe_n && !was_off) begin
			keep(last, run);
		end else begin
			run++;
		end
		last = i_line;
		was_off = i_oe_n;
	end
endmodule
`default_nettype wire

// File: verif/test_ckg_clock_route.sv
// Self-checking bench for the clock router
`timescale 1ns/100ps
`default_nettype none
module test_ckg_clock_route;
	localparam int NO = 8;
	localparam int XH = 2;
	localparam int EH = 3;
	logic          clk = 1'b0;
	logic          rst_n = 1'b0;
	logic [5:0]    adr = 6'h00;
	logic          rd = 1'b0;
	logic          wr = 1'b0;
	logic [31:0]   wdat = 32'h0;
	logic [3:0]    be = 4'hf;
	logic [31:0]   rdat;
	logic          wait_r;
	logic          crystal_ref = 1'b0;
	logic          ext = 1'b0;
	logic          gate_n = 1'b1;
	logic          ssd = 1'b1;
	logic [3:0]    sup = 4'hf;
	logic [NO-1:0] oclk;
	logic [NO-1:0] oe_n;
	logic          sel1;
	logic          sel2;
	logic [1:0]    code;
	logic          clr = 1'b1;
	int            err_count = 0;
	int            n_checks = 0;
	int            cyc = 0;
	int            xc = 0;
	int            ec = 0;
	int            rise[2], mnh[2], mxh[2], mnl[2], mxl[2];
	logic          first[2];

	ckg_clock_route #(.NUM_OUT(NO)) dut (.i_ref_clk(clk), .i_reset_n(rst_n),
		.i_avs_address(adr), .i_avs_read(rd), .i_avs_write(wr), .i_avs_writedata(wdat),
		.i_avs_byteenable(be), .o_avs_readdata(rdat), .o_avs_waitrequest(wait_r),
		.i_crystal_ref(crystal_ref), .i_external_ref_input(ext), .i_output_gate_pin_n(gate_n),
		.i_spread_defeat_pin(ssd), .i_bank_output_supply(sup), .o_clk(oclk),
		.o_clk_oe_n(oe_n), .o_first_pll_ref_sel(sel1), .o_second_pll_ref_sel(sel2),
		.o_ext_div_code(code));
	for (genvar g = 0; g < 2; g++) begin : g_sink
		ckg_clk_sink sink (.i_ref_clk(clk), .i_clear(clr), .i_line(oclk[g]),
			.i_oe_n(oe_n[g]), .o_rises(rise[g]), .o_min_hi(mnh[g]), .o_max_hi(mxh[g]),
			.o_min_lo(mnl[g]), .o_max_lo(mxl[g]), .o_first(first[g]));
	end

	always #50 clk = ~clk;

	// Reference clocks, slow enough for edge detection
	always @(posedge clk) begin
		cyc <= cyc + 1;
		xc <= (xc == XH - 1) ? 0 : xc + 1;
		ec <= (ec == EH - 1) ? 0 : ec + 1;
		if (xc == XH - 1)
			crystal_ref <= ~crystal_ref;
		if (ec == EH - 1)
			ext <= ~ext;
		if (cyc == 20000) begin
			err_count++;
			report_and_stop();
		end
	end

	task report_and_stop;
		$display("checks %0d mismatches %0d", n_checks, err_count);
		if (err_count == 0 && n_checks > 0)
			$display("NO MISMATCHES");
		else
			$display("MISMATCHES SEEN");
		$finish;
	endtask

	task chk(input string nm, input logic [31:0] exp, input logic [31:0] got);
		n_checks++;
		if (got !== exp) begin
			err_count++;
			$display("CHECK FAILED %s expected %h seen %h", nm, exp, got);
		end
	endtask

	task bus(input logic w, input logic [5:0] a, input logic [31:0] d, output logic [31:0] q);
		int n;
		n = 0;
		@(posedge clk);
		rd <= !w;
		wr <= w;
		adr <= a;
		wdat <= d;
		// Look at the settled answer mid-cycle; it takes effect at the next rising edge
		@(negedge clk);
		while (wait_r !== 1'b0 && n < 50) begin
			@(negedge clk);
			n++;
		end
		q = rdat;
		if (n >= 50)
			chk("bus answer", 32'h0, 32'h1);
		@(posedge clk);
		rd <= 1'b0;
		wr <= 1'b0;
	endtask

	task wreg(input logic [5:0] a, input logic [31:0] d);
		logic [31:0] q;
		bus(1'b1, a, d, q);
	endtask

	task rchk(input logic [5:0] a, input logic [31:0] exp, input string nm);
		logic [31:0] q;
		bus(1'b0, a, 32'h0, q);
		chk(nm, exp, q);
	endtask

	task t_reset;
		rchk(6'h00, 32'h0000_0028, "ctrl");
		rchk(6'h01, 32'h0000_0000, "enable");
		rchk(6'h08, 32'h0004_0010, "out0");
		rchk(6'h05, 32'h0000_0000, "unmapped");
		chk("ext code", 32'h0, {30'h0, code});
	endtask

	// Input divider boundaries with every select pair
	task t_route;
		int mhz[6] = '{10, 30, 31, 60, 61, 100};
		int cd[6] = '{0, 0, 1, 1, 2, 2};
		logic [31:0] d;
		for (int i = 0; i < 6; i++) begin
			d = 32'((mhz[i] << 2) | (i % 4));
			wreg(6'h00, d);
			rchk(6'h00, d, "ctrl");
			chk("first sel", 32'(i % 2), {31'h0, sel1});
			chk("second sel", 32'((i / 2) % 2), {31'h0, sel2});
			chk("ext code", 32'(cd[i]), {30'h0, code});
		end
	endtask

	task t_pins;
		logic [31:0] q;
		for (int i = 0; i < 4; i++) begin
			gate_n <= i[0];
			ssd <= i[1];
			repeat (6) @(posedge clk);
			bus(1'b0, 6'h02, 32'h0, q);
			chk("status pins", 32'(i), {30'h0, q[9:8]});
		end
	endtask

	task run(input logic [31:0] en);
		wreg(6'h01, en);
		clr <= 1'b1;
		@(posedge clk);
		clr <= 1'b0;
		gate_n <= 1'b0;
		repeat (400) @(posedge clk);
		gate_n <= 1'b1;
		repeat (200) @(posedge clk);
	endtask

	task widths(input int p, input int half, input logic fl);
		chk("high min", 32'(half), 32'(mnh[p]));
		chk("high max", 32'(half), 32'(mxh[p]));
		chk("low min", 32'(half), 32'(mnl[p]));
		chk("low max", 32'(half), 32'(mxl[p]));
		chk("first level", {31'h0, fl}, {31'h0, first[p]});
	endtask

	task t_gate;
		wreg(6'h00, 32'h0000_00aa);
		wreg(6'h08, 32'h0002_0018);
		wreg(6'h09, 32'h0002_0019);
		run(32'h1);
		widths(0, 2 * XH * 2 * 2, 1'b1);
		chk("idle output rises", 32'h0, 32'(rise[1]));
		chk("parked hiz", 32'h3, {30'h0, oe_n[1:0]});
		wreg(6'h08, 32'h0002_001a);
		run(32'h3);
		widths(0, 2 * XH * 2 * 2, 1'b0);
		widths(1, 2 * EH * 2 * 2 * 2, 1'b1);
		wreg(6'h08, 32'h0002_0028);
		run(32'h1);
		widths(0, 2 * XH * 2 * 4, 1'b1);
		gate_n <= 1'b0;
		repeat (100) @(posedge clk);
		sup <= 4'he;
		repeat (4) @(posedge clk);
		chk("bank off", 32'h3, {30'h0, oe_n[1:0]});
		sup <= 4'hf;
		gate_n <= 1'b1;
	endtask

	initial begin
		repeat (20) @(posedge clk);
		rst_n <= 1'b1;
		t_reset();
		t_route();
		t_pins();
		t_gate();
		report_and_stop();
	end
endmodule
`default_nettype wire
